// File: logic/dual_dptr_pkg.sv
// constants and types shared by the dual address pointer block
package dual_dptr_pkg;

  // widths
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned PTR_W      = 16;
  localparam int unsigned SFR_ADDR_W = 8;
  localparam int unsigned NUM_PTRS   = 2;

  // register-space addresses
  localparam logic [7:0] ADDR_PTR0_LOW  = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW  = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_SELECTION = 8'h86;

  // reset values and field layout
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [7:0]  SELECTION_RESET = 8'h00;
  localparam int unsigned SEL_BIT_POS    = 0;
  localparam logic [6:0]  SEL_RESERVED   = 7'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
  localparam logic [7:0]  ACC_PAD        = 8'h00;
  localparam int unsigned INC_STEP       = 1;

  // pointer operations issued by the core, one-hot
  typedef enum logic [6:0] {
    op_none        = 7'h01,
    op_inc         = 7'h02,
    op_load        = 7'h04,
    op_code_read   = 7'h08,
    op_xdata_read  = 7'h10,
    op_xdata_write = 7'h20,
    op_jump        = 7'h40
  } ptr_op_type;

endpackage

// File: logic/ptr_port_if.sv
// control and value bundle between the selector and one pointer store
interface ptr_port_if #(
  parameter int unsigned W = 16
) ();
  logic             wr_low;
  logic             wr_high;
  logic [W/2-1:0]   wr_byte;
  logic             load;
  logic [W-1:0]     load_value;
  logic             inc;
  logic [W-1:0]     value;

  modport ctrl  (output wr_low, wr_high, wr_byte, load, load_value, inc,
                 input  value);
  modport store (input  wr_low, wr_high, wr_byte, load, load_value, inc,
                 output value);
endinterface

// File: logic/pointer_store.sv
// one 16-bit address pointer with byte writes, load and increment
module pointer_store #(
  parameter int unsigned W = dual_dptr_pkg::PTR_W
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  ptr_port_if.store  port
);

  localparam int unsigned H = W / 2;

  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;
  logic [W-1:0] incremented;

  // whole-word add: low byte carries into high, all ones wraps to zero
  assign incremented = value_reg + W'(dual_dptr_pkg::INC_STEP);

  // load beats increment; direct byte writes land last
  always_comb begin
    value_next = value_reg;
    if (port.load) begin
      value_next = port.load_value;
    end else if (port.inc) begin
      value_next = incremented;
    end
    if (port.wr_low) begin
      value_next[H-1:0] = port.wr_byte;
    end
    if (port.wr_high) begin
      value_next[W-1:H] = port.wr_byte;
    end
  end

  // pointer bytes clear on reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      value_reg <= W'(dual_dptr_pkg::PTR_RESET);
    end else begin
      value_reg <= value_next;
    end
  end

  assign port.value = value_reg;

endmodule

// File: logic/dual_data_pointer_select.sv
// two external-memory address pointers with a selection register
module dual_data_pointer_select #(
  parameter int unsigned PTR_W  = dual_dptr_pkg::PTR_W,
  parameter int unsigned BYTE_W = dual_dptr_pkg::BYTE_W
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // direct register-space access from the core
  input  wire logic [7:0]                i_sfr_addr,
  input  wire logic                      i_sfr_wr,
  input  wire logic [BYTE_W-1:0]         i_sfr_wdata,
  input  wire logic                      i_sfr_rd,
  output logic      [BYTE_W-1:0]         o_sfr_rdata,
  output logic                           o_sfr_ack,
  // pointer instructions from the core
  input  wire logic                      i_op_valid,
  input  wire dual_dptr_pkg::ptr_op_type i_op,
  input  wire logic [PTR_W-1:0]          i_op_const,
  input  wire logic [BYTE_W-1:0]         i_acc,
  output logic                           o_op_done,
  output logic                           o_op_refused,
  // memory address handed to the bus unit
  output logic                           o_mem_valid,
  output dual_dptr_pkg::ptr_op_type      o_mem_op,
  output logic      [PTR_W-1:0]          o_mem_addr,
  output logic                           o_mem_ptr_id,
  // state views
  output logic                           o_select_bit,
  output logic      [PTR_W-1:0]          o_pointer0,
  output logic      [PTR_W-1:0]          o_pointer1
);

  localparam int unsigned NUM = dual_dptr_pkg::NUM_PTRS;
  localparam int unsigned H   = PTR_W / 2;

  // selection register state
  logic sel_reg;
  logic sel_next;

  // pointer values from the two stores
  logic [PTR_W-1:0] ptr_val [NUM];

  // registered outputs and the next values feeding them
  logic [BYTE_W-1:0]         rdata_reg;
  logic [BYTE_W-1:0]         rdata_next;
  logic                      ack_reg;
  logic                      op_done_reg;
  logic                      op_refused_reg;
  logic                      mem_valid_reg;
  dual_dptr_pkg::ptr_op_type mem_op_reg;
  dual_dptr_pkg::ptr_op_type mem_op_next;
  logic [PTR_W-1:0]          mem_addr_reg;
  logic [PTR_W-1:0]          mem_addr_next;
  logic                      mem_ptr_id_reg;

  // address decode of the register space
  wire hit_p0_low  = (i_sfr_addr == dual_dptr_pkg::ADDR_PTR0_LOW);
  wire hit_p0_high = (i_sfr_addr == dual_dptr_pkg::ADDR_PTR0_HIGH);
  wire hit_p1_low  = (i_sfr_addr == dual_dptr_pkg::ADDR_PTR1_LOW);
  wire hit_p1_high = (i_sfr_addr == dual_dptr_pkg::ADDR_PTR1_HIGH);
  wire hit_sel     = (i_sfr_addr == dual_dptr_pkg::ADDR_SELECTION);
  wire sfr_hit     = hit_p0_low | hit_p0_high | hit_p1_low | hit_p1_high
                   | hit_sel;

  // write strobes per register, taken whatever the selection is
  wire wr_p0_low  = i_sfr_wr & hit_p0_low;
  wire wr_p0_high = i_sfr_wr & hit_p0_high;
  wire wr_p1_low  = i_sfr_wr & hit_p1_low;
  wire wr_p1_high = i_sfr_wr & hit_p1_high;
  wire wr_sel     = i_sfr_wr & hit_sel;

  // per-pointer strobe vectors for the generate loop
  wire [NUM-1:0] wr_low_vec  = {wr_p1_low, wr_p0_low};
  wire [NUM-1:0] wr_high_vec = {wr_p1_high, wr_p0_high};

  // selection bit: only bit 0 is stored, the rest is fixed at zero
  assign sel_next = wr_sel ? i_sfr_wdata[dual_dptr_pkg::SEL_BIT_POS]
                           : sel_reg;

  // instruction decode; anything not a legal code is ignored
  wire is_inc   = i_op_valid & (i_op == dual_dptr_pkg::op_inc);
  wire is_load  = i_op_valid & (i_op == dual_dptr_pkg::op_load);
  wire is_code  = i_op_valid & (i_op == dual_dptr_pkg::op_code_read);
  wire is_xrd   = i_op_valid & (i_op == dual_dptr_pkg::op_xdata_read);
  wire is_xwr   = i_op_valid & (i_op == dual_dptr_pkg::op_xdata_write);
  wire is_jump  = i_op_valid & (i_op == dual_dptr_pkg::op_jump);
  wire is_mem   = is_code | is_xrd | is_xwr | is_jump;
  wire is_mod   = is_inc | is_load;

  // a direct write to the selected pointer in the same cycle wins;
  // the dropped modify is reported on o_op_refused in the next cycle
  wire wr_selected_ptr = sel_reg ? (wr_p1_low | wr_p1_high)
                                 : (wr_p0_low | wr_p0_high);
  wire mod_refused     = is_mod & wr_selected_ptr;
  wire mod_taken       = is_mod & ~wr_selected_ptr;

  // the selected pointer; a selection write acts from the next cycle
  wire [PTR_W-1:0] selected_ptr = sel_reg ? ptr_val[1]
                                          : ptr_val[0];

  // accumulator-relative address wraps inside 16 bits
  wire [PTR_W-1:0] acc_wide    = {dual_dptr_pkg::ACC_PAD, i_acc};
  wire [PTR_W-1:0] indexed_ptr = selected_ptr + acc_wide;
  wire             use_indexed = is_code | is_jump;

  assign mem_addr_next = use_indexed ? indexed_ptr : selected_ptr;
  assign mem_op_next   = is_mem ? i_op : dual_dptr_pkg::op_none;

  // pointer stores, one per pointer; each sees modify only if selected
  ptr_port_if #(.W(PTR_W)) port_bus [NUM] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi++) begin : g_ptr
      wire is_selected = (sel_reg == 1'(gi));
      assign port_bus[gi].wr_low     = wr_low_vec[gi];
      assign port_bus[gi].wr_high    = wr_high_vec[gi];
      assign port_bus[gi].wr_byte    = i_sfr_wdata;
      assign port_bus[gi].load       = mod_taken & is_load & is_selected;
      assign port_bus[gi].load_value = i_op_const;
      assign port_bus[gi].inc        = mod_taken & is_inc & is_selected;
      assign ptr_val[gi]             = port_bus[gi].value;

      pointer_store #(
        .W (PTR_W)
      ) u_store (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .port  (port_bus[gi])
      );
    end
  endgenerate

  // read data mux; reserved selection bits and unmapped space read zero
  wire [BYTE_W-1:0] sel_read = {dual_dptr_pkg::SEL_RESERVED,
                                sel_reg};
  assign rdata_next =
      hit_p0_low  ? ptr_val[0][H-1:0]     :
      hit_p0_high ? ptr_val[0][PTR_W-1:H] :
      hit_p1_low  ? ptr_val[1][H-1:0]     :
      hit_p1_high ? ptr_val[1][PTR_W-1:H] :
      hit_sel     ? sel_read              :
                    dual_dptr_pkg::UNMAPPED_READ;

  // selection register: cleared on reset so pointer zero is active
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_reg <= dual_dptr_pkg::SELECTION_RESET[0];
    end else begin
      sel_reg <= sel_next;
    end
  end

  // register read port; data holds until the next read, mapped or not
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= dual_dptr_pkg::UNMAPPED_READ;
      ack_reg   <= 1'b0;
    end else begin
      if (i_sfr_rd) begin
        rdata_reg <= rdata_next;
      end
      ack_reg <= (i_sfr_rd | i_sfr_wr) & sfr_hit;
    end
  end

  // memory request and instruction status; valid, done and refused pulse, address and pointer id hold until the next memory op
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_valid_reg  <= 1'b0;
      mem_op_reg     <= dual_dptr_pkg::op_none;
      mem_addr_reg   <= dual_dptr_pkg::PTR_RESET;
      mem_ptr_id_reg <= 1'b0;
      op_done_reg    <= 1'b0;
      op_refused_reg <= 1'b0;
    end else begin
      mem_valid_reg  <= is_mem;
      mem_op_reg     <= mem_op_next;
      op_done_reg    <= is_mem | mod_taken;
      op_refused_reg <= mod_refused;
      if (is_mem) begin
        mem_addr_reg   <= mem_addr_next;
        mem_ptr_id_reg <= sel_reg;
      end
    end
  end

  // outputs come straight from flip-flops
  assign o_sfr_rdata  = rdata_reg;
  assign o_sfr_ack    = ack_reg;
  assign o_op_done    = op_done_reg;
  assign o_op_refused = op_refused_reg;
  assign o_mem_valid  = mem_valid_reg;
  assign o_mem_op     = mem_op_reg;
  assign o_mem_addr   = mem_addr_reg;
  assign o_mem_ptr_id = mem_ptr_id_reg;
  assign o_select_bit = sel_reg;
  assign o_pointer0   = ptr_val[0];
  assign o_pointer1   = ptr_val[1];

endmodule

// File: verif/dual_data_pointer_select_props.sv
// assertion checker on the dual address pointer block ports
module dual_data_pointer_select_props (
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire logic [7:0]                i_sfr_addr,
  input wire logic                      i_sfr_wr,
  input wire logic [7:0]                i_sfr_wdata,
  input wire logic                      i_sfr_rd,
  input wire logic [7:0]                o_sfr_rdata,
  input wire logic                      o_sfr_ack,
  input wire logic                      i_op_valid,
  input wire dual_dptr_pkg::ptr_op_type i_op,
  input wire logic                      o_mem_valid,
  input wire logic [15:0]               o_mem_addr,
  input wire logic                      o_mem_ptr_id,
  input wire logic                      o_select_bit,
  input wire logic [15:0]               o_pointer0,
  input wire logic [15:0]               o_pointer1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // decode; illegal op codes are left out of the memory-op antecedents
  wire logic        hit = (i_sfr_wr | i_sfr_rd) &&
                          i_sfr_addr inside {[8'h82:8'h86]};
  wire logic        sel_wr = i_sfr_wr && i_sfr_addr == 8'h86;
  wire logic        mem_op = i_op_valid && $onehot(i_op) &&
                             (i_op & 7'h78) != 7'h00;
  wire logic [15:0] cur = o_select_bit ? o_pointer1 : o_pointer0;

  a_ack_mapped: assert property (hit |=> o_sfr_ack)
    else $error("ack missing");
  a_sel_write: assert property (sel_wr |=>
    o_select_bit == $past(i_sfr_wdata[0])) else $error("select lost");
  a_sel_hold: assert property (!sel_wr |=> $stable(o_select_bit))
    else $error("select moved");
  a_sel_read: assert property (i_sfr_rd && i_sfr_addr == 8'h86 |=>
    o_sfr_rdata == {7'h00, $past(o_select_bit)}) else $error("bad select");
  a_mem_ptr: assert property (mem_op |=> o_mem_valid &&
    o_mem_ptr_id == $past(o_select_bit)) else $error("wrong pointer");
  a_xdata_addr: assert property (mem_op &&
    (i_op & 7'h30) != 7'h00 |=> o_mem_addr == $past(cur))
    else $error("bad address");
  a_inc_carry: assert property (i_op_valid && !i_sfr_wr &&
    i_op == dual_dptr_pkg::op_inc |=> cur == $past(cur) + 16'h0001)
    else $error("bad increment");
  a_other_kept: assert property (i_op_valid && !i_sfr_wr &&
    !o_select_bit |=> $stable(o_pointer1)) else $error("other touched");
endmodule

bind dual_data_pointer_select dual_data_pointer_select_props props (
  .i_clk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd,
  .o_sfr_rdata, .o_sfr_ack, .i_op_valid, .i_op, .o_mem_valid,
  .o_mem_addr, .o_mem_ptr_id, .o_select_bit, .o_pointer0, .o_pointer1);

// File: verif/core_model.sv
// behavioural core issuing register accesses and pointer instructions
module core_model (
  input  wire logic                 i_clk,
  output logic [7:0]                o_addr,
  output logic                      o_wr,
  output logic [7:0]                o_wdata,
  output logic                      o_rd,
  output logic                      o_valid,
  output dual_dptr_pkg::ptr_op_type o_op,
  output logic [15:0]               o_const
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle values at time zero
  initial begin
    {o_addr, o_wr, o_wdata, o_rd, o_valid, o_const} = '0;
    o_op = dual_dptr_pkg::op_none;
  end
  // one core cycle; released data flips so stale values never look valid
  task automatic step(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input dual_dptr_pkg::ptr_op_type op,
                      input logic [15:0] c);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= r;
    o_addr <= a;
    o_wdata <= d;
    o_valid <= op != dual_dptr_pkg::op_none;
    o_op <= op;
    o_const <= c;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_valid <= 1'b0;
    o_op <= dual_dptr_pkg::op_none;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
endmodule

// File: verif/dual_data_pointer_select_tb_top.sv
// self-checking bench for the dual address pointer block
module dual_data_pointer_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam dual_dptr_pkg::ptr_op_type no_op = dual_dptr_pkg::op_none;
  logic                      i_clk = 1'b0;
  logic                      i_rst = 1'b1;
  logic [7:0]                addr, wdata, rdata;
  logic [7:0]                acc = 8'h03;
  logic                      wr, rd, valid, ack, done, refused, mvalid, pid;
  logic                      sel;
  logic [15:0]               opc, maddr, p0, p1;
  dual_dptr_pkg::ptr_op_type op, mop;
  int                        error_cnt = 0;
  int                        checked = 0;
  int                        cycles = 0;
  // clock, and a ceiling well above the roughly 75 cycles needed
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  core_model cm (.i_clk, .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
    .o_rd(rd), .o_valid(valid), .o_op(op), .o_const(opc));
  dual_data_pointer_select dut (.i_clk, .i_rst, .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
    .o_sfr_ack(ack), .i_op_valid(valid), .i_op(op), .i_op_const(opc),
    .i_acc(acc), .o_op_done(done), .o_op_refused(refused),
    .o_mem_valid(mvalid), .o_mem_op(mop), .o_mem_addr(maddr),
    .o_mem_ptr_id(pid), .o_select_bit(sel), .o_pointer0(p0),
    .o_pointer1(p1));
  // comparison and access helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cm.step(1'b1, 1'b0, a, d, no_op, 16'h0000);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    cm.step(1'b0, 1'b1, a, 8'h00, no_op, 16'h0000);
  endtask
  // every register reads its reset value with an ack
  task automatic t_reset_values();
    for (int a = 8'h82; a <= 8'h86; a++) begin
      rd_reg(8'(a));
      chk({ack, rdata}, 9'h100);
    end
  endtask
  // direct bytes reach pointer 1, pointer 0 is loaded; the place above stays dead
  task automatic t_direct_bytes();
    logic [7:0] exp [4] = '{8'h34, 8'h12, 8'h5a, 8'ha5};
    cm.step(1'b0, 1'b0, 8'h00, 8'h00, dual_dptr_pkg::op_load, 16'h1234);
    chk(p0, 16'h1234);
    wr_reg(8'h84, 8'h5a);
    wr_reg(8'h85, 8'ha5);
    chk(p1, 16'ha55a);
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'h82 + 8'(i));
      chk(rdata, exp[i]);
    end
    rd_reg(8'h87);
    chk({ack, rdata}, 9'h000);
  endtask
  // reserved bits read zero; the next instruction follows the switch
  task automatic t_select();
    wr_reg(8'h86, 8'hff);
    rd_reg(8'h86);
    chk({sel, rdata}, 9'h101);
    cm.step(1'b0, 1'b0, 8'h00, 8'h00, dual_dptr_pkg::op_load, 16'hbeef);
    chk(p1, 16'hbeef);
    chk(p0, 16'h1234);
  endtask
  // the four memory operations through each pointer in turn
  task automatic t_mem_ops();
    dual_dptr_pkg::ptr_op_type o;
    logic [15:0]               base;
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'h86, 8'(s));
      base = (s == 1) ? 16'hbeef : 16'h1234;
      for (int k = 3; k < 7; k++) begin
        o = dual_dptr_pkg::ptr_op_type'(7'h01 << k);
        cm.step(1'b0, 1'b0, 8'h00, 8'h00, o, 16'h0000);
        chk({mvalid, done, pid, mop}, {2'b11, 1'(s), o});
        chk(maddr, base + ((k % 3 == 0) ? 16'h0003 : 16'h0000));
      end
    end
    // a larger accumulator carries into the high byte of the address
    @(posedge i_clk);
    acc <= 8'h20;
    cm.step(1'b0, 1'b0, 8'h00, 8'h00, dual_dptr_pkg::op_code_read, 16'h0000);
    chk(maddr, 16'hbf0f);
  endtask
  // increment wraps, carries, and yields to a colliding write
  task automatic t_inc_refuse();
    wr_reg(8'h84, 8'hff);
    wr_reg(8'h85, 8'hff);
    cm.step(1'b0, 1'b0, 8'h00, 8'h00, dual_dptr_pkg::op_inc, 16'h0000);
    chk(p1, 16'h0000);
    wr_reg(8'h84, 8'hff);
    cm.step(1'b0, 1'b0, 8'h00, 8'h00, dual_dptr_pkg::op_inc, 16'h0000);
    chk(p1, 16'h0100);
    cm.step(1'b1, 1'b0, 8'h84, 8'h77, dual_dptr_pkg::op_inc, 16'h0000);
    chk({refused, done, p1}, {2'b10, 16'h0177});
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset for eight cycles, then the scenarios in order
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_values();
    t_direct_bytes();
    t_select();
    t_mem_ops();
    t_inc_refuse();
    test_done();
  end
endmodule
